/* File: verilog/printer_digit_readout_sequencer.sv */
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "readout_map.svh"
// Operation
// RQ1: decades are strobed one per slot, most significant decade first.
// RQ2: one command slot always follows the least significant digit.
// RQ3: four-bit word length counts digit slots plus the command slot.
// RQ4: active-low strobes go to order points ascending from one, via a mapping.
// RQ5: start is gated by channel 0 active, channel 1 inactive, burst active.
// RQ6: qualified start runs the generator; each pulse begins one slot.
// RQ7: each pulse advances a four-bit slot counter that selects the strobe.
// RQ8: at the word length the generator stops and the counter clears.
// RQ9: each pulse gives a coincident active-low sync of fixed width.
// RQ10: idle selection suppresses sync so nothing prints.
// RQ11: four data lines carry weights 1..8 of the strobed decade.
// RQ12: data lines five and six sit at mark permanently.
// RQ13: command gives CR/LF after 15, space after other odd but 1, else idle.
// RQ14: mark is logic one, space logic zero, on data and sync alike.
// RQ15: the measurement-complete pulse is the start of readout.
// RQ16: pulse width and period come from a programmable clock divider.
module printer_digit_readout_sequencer
#(
   parameter logic [19:0] PULSE_CYC  = 20'(`RO_PULSE_NS / `RO_CLK_NS),
   parameter logic [19:0] PERIOD_CYC = 20'(`RO_PERIOD_NS / `RO_CLK_NS)
)
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   input  wire logic        meas_done_in,
   input  wire logic        ch0_active_in,
   input  wire logic        ch1_active_in,
   input  wire logic        burst_flag_in,
   input  wire logic [3:0]  channel_in,
   input  wire logic [31:0] decades_in,
   input  wire logic        printer_ready_in,
   output logic [5:0]       data_out,
   output logic [15:0]      strobe_n_out,
   output logic             sync_n_out
);
   import readout_pkg::*;
   localparam logic [19:0] SYNC_CYC = 20'(`RO_SYNC_CYC);

   seq_state_t st_q;
   seq_state_t st_d;
   logic       qualified;
   logic       launch;
   logic       pulse;
   logic       push;
   logic       push_ready;
   logic       pop;
   logic       pop_valid;
   logic [3:0] src;
   logic [3:0] digit;
   logic [3:0] cmd;
   logic [3:0] point;
   logic [3:0] slot_code;
   buf_word_t  push_word;
   buf_word_t  pop_word;

   assign rdata_out    = st_q.rdata;
   assign data_out     = st_q.data;
   assign strobe_n_out = st_q.strobe_n;
   assign sync_n_out   = st_q.sync_n;

   // start gating from the synchronised channel levels
   assign qualified = st_q.s2[2] & ~st_q.s2[1] & st_q.s2[0]; // RQ5
   assign launch = st_q.pending & qualified & ~st_q.running & (st_q.word_len != 4'h0);
   // a pulse waits while the buffer is full, so no slot is lost
   assign pulse = st_q.running & (st_q.phase == 20'h0);
   assign push  = pulse & push_ready;
   assign point = st_q.slot + 4'h1; // RQ4
   assign src   = st_q.pmap[4 * point +: 4];

   // or-combine each weight across the eight decades
   genvar b;
   generate
      for (b = 0; b < 4; b++)
      begin : g_weight
         logic [7:0] hit;
         for (genvar d = 0; d < 8; d++)
         begin : g_dec
            assign hit[d] = (src == 4'(d)) & decades_in[4 * d + b];
         end
         assign digit[b] = |hit; // RQ11
      end
   endgenerate

   // command choice by channel number
   always_comb
   begin
      if (channel_in == 4'hF)
         cmd = `RO_CMD_CRLF; // RQ13
      else if (channel_in[0] && channel_in != 4'h1)
         cmd = `RO_CMD_SPACE;
      else
         cmd = `RO_CMD_IDLE;
   end

   // the command code takes the slot whose mapped source is the command slot code
   assign slot_code = (src == `RO_SRC_CMD) ? cmd : digit; // RQ2
   // lines five and six fixed at mark
   assign push_word = {point, 2'b11, slot_code}; // RQ12

   readout_slot_buffer u_buf
   (
      .mclk_in      (mclk_in),
      .rst_in       (rst_in),
      .ce_in        (ce_in),
      .in_valid_in  (pulse),
      .in_ready_out (push_ready),
      .in_data_in   (push_word),
      .out_valid_out(pop_valid),
      .out_ready_in (printer_ready_in & ~st_q.emitting),
      .out_data_out (pop_word)
   );
   assign pop = pop_valid & printer_ready_in & ~st_q.emitting;

   // next state: sync, registers, generator, slot counter, emission
   always_comb
   begin
      st_d = st_q;
      st_d.s1 = {ch0_active_in, ch1_active_in, burst_flag_in};
      st_d.s2 = st_q.s1;
      st_d.rdata = 32'h0;
      if (meas_done_in)
         st_d.pending = 1'b1; // RQ15
      else if (launch)
         st_d.pending = 1'b0;
      if (wr_in)
      begin
         unique case (addr_in)
            `RO_CTRL_OFS:
            begin
               st_d.word_len = wdata_in[`RO_LEN_MSB:`RO_LEN_LSB]; // RQ3
               st_d.operate  = wdata_in[`RO_OPERATE_BIT];
            end
            `RO_MAP_LO_OFS: st_d.pmap[31:0]  = wdata_in;
            `RO_MAP_HI_OFS: st_d.pmap[63:32] = wdata_in;
            `RO_PERIOD_OFS: st_d.period = wdata_in[19:0]; // RQ16
            `RO_WIDTH_OFS:  st_d.width  = wdata_in[19:0];
            default: ;
         endcase
      end
      if (rd_in)
      begin
         unique case (addr_in)
            `RO_CTRL_OFS:   st_d.rdata = {27'h0, st_q.operate, st_q.word_len};
            `RO_MAP_LO_OFS: st_d.rdata = st_q.pmap[31:0];
            `RO_MAP_HI_OFS: st_d.rdata = st_q.pmap[63:32];
            `RO_PERIOD_OFS: st_d.rdata = {12'h0, st_q.period};
            `RO_WIDTH_OFS:  st_d.rdata = {12'h0, st_q.width};
            `RO_STATUS_OFS: st_d.rdata = {25'h0, st_q.emitting, st_q.slot,
                                          st_q.pending, st_q.running};
            default:        st_d.rdata = 32'h0;
         endcase
      end
      if (launch)
      begin
         st_d.running = 1'b1; // RQ6
         st_d.phase   = 20'h0;
         st_d.slot    = 4'h0;
      end
      else if (st_q.running)
      begin
         if (push)
         begin
            st_d.phase = 20'h1;
            if (point == st_q.word_len)
            begin
               st_d.running = 1'b0; // RQ8
               st_d.slot    = 4'h0;
            end
            else
               st_d.slot = point; // RQ7
         end
         else if (!pulse)
            st_d.phase = (st_q.phase + 20'h1 >= st_q.period) ? 20'h0 : st_q.phase + 20'h1;
      end
      // emission of one buffered slot
      if (pop)
      begin
         st_d.emitting = 1'b1;
         st_d.emit_cnt = 20'h1;
         st_d.data     = pop_word[5:0];
         st_d.strobe_n = ~(16'h1 << pop_word[9:6]); // RQ1
         st_d.sync_n   = ~st_q.operate; // RQ10
      end
      else if (st_q.emitting)
      begin
         st_d.emit_cnt = st_q.emit_cnt + 20'h1;
         if (st_q.emit_cnt >= st_q.width)
            st_d.strobe_n = 16'hFFFF;
         if (st_q.emit_cnt >= SYNC_CYC || !st_q.operate)
            st_d.sync_n = 1'b1; // RQ9
         if (st_q.emit_cnt >= st_q.width && st_q.emit_cnt >= SYNC_CYC)
         begin
            st_d.emitting = 1'b0;
            st_d.data     = 6'h30; // RQ14
         end
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         st_q          <= '0;
         st_q.strobe_n <= 16'hFFFF;
         st_q.sync_n   <= 1'b1;
         st_q.data     <= 6'h30;
         st_q.word_len <= `RO_LEN_RST;
         st_q.operate  <= `RO_OPERATE_RST;
         st_q.pmap     <= `RO_MAP_RST;
         st_q.period   <= PERIOD_CYC;
         st_q.width    <= PULSE_CYC;
      end
      else if (ce_in)
         st_q <= st_d;
   end

   // checks on the sequencing
   default clocking cb @(posedge mclk_in iff ce_in); endclocking
   default disable iff (rst_in);

   a_start_gating: assert property ($rose(st_q.running) |-> $past(qualified)) // RQ5
      else $error("generator started without qualified start");
   a_first_slot: assert property ($rose(st_q.running) |-> st_q.slot == 4'h0) // RQ4
      else $error("readout did not begin at order point one");
   a_stop_clear: assert property ($fell(st_q.running) |-> st_q.slot == 4'h0 // RQ8
                                  && $past(point) == $past(st_q.word_len))
      else $error("generator stopped at wrong count");
   a_slot_step: assert property (push && point != st_q.word_len |=> st_q.slot == $past(point)) // RQ7
      else $error("slot counter did not advance");
   a_strobe_single: assert property ($onehot0(~strobe_n_out) && strobe_n_out[0]) // RQ1
      else $error("more than one order point strobed");
   a_marks_held: assert property (data_out[5:4] == 2'b11) // RQ12
      else $error("lines five and six left mark");
   a_idle_no_sync: assert property (!st_q.operate ##1 !st_q.operate |-> sync_n_out) // RQ10
      else $error("sync issued while idle");
   a_sync_coincide: assert property ($fell(sync_n_out) |-> strobe_n_out != 16'hFFFF // RQ9
                                     && st_q.emit_cnt == 20'h1)
      else $error("sync not coincident with strobe");
   a_sync_bound: assert property (!sync_n_out |-> st_q.emit_cnt <= SYNC_CYC) // RQ9
      else $error("sync pulse too long");
   a_cmd_crlf: assert property (push && src == `RO_SRC_CMD && channel_in == 4'hF // RQ13
                                |-> push_word[3:0] == `RO_CMD_CRLF)
      else $error("command slot after channel 15 not CR/LF");

   c_readout_done: cover property ($fell(st_q.running));
   c_cmd_slot: cover property (push && src == `RO_SRC_CMD);
   c_buffer_stall: cover property (pulse && !push_ready);
endmodule
`default_nettype wire

/* File: inc/readout_map.svh */
`ifndef READOUT_MAP_SVH
`define READOUT_MAP_SVH
// register byte offsets
`define RO_CTRL_OFS      8'h00
`define RO_MAP_LO_OFS    8'h04
`define RO_MAP_HI_OFS    8'h08
`define RO_PERIOD_OFS    8'h0C
`define RO_WIDTH_OFS     8'h10
`define RO_STATUS_OFS    8'h14
// control fields
`define RO_LEN_LSB       0
`define RO_LEN_MSB       3
`define RO_OPERATE_BIT   4
// reset values
`define RO_LEN_RST       4'h0
`define RO_OPERATE_RST   1'b0
`define RO_MAP_RST       64'h0000_0000_0000_0000
// order-point source codes: 0..7 decade index, 8 command slot
`define RO_SRC_CMD       4'h8
// command codes on the four weighted data lines
`define RO_CMD_IDLE      4'h0
`define RO_CMD_SPACE     4'h1
`define RO_CMD_CRLF      4'h2
// timing in ns and clock period
`define RO_CLK_NS        5
`define RO_PULSE_NS      40000
`define RO_PERIOD_NS     2000000
`define RO_SYNC_NS       20000
`define RO_SYNC_CYC      (`RO_SYNC_NS / `RO_CLK_NS)
`endif

/* File: inc/readout_pkg.sv */
package readout_pkg;
   typedef logic [9:0] buf_word_t; // {order point, data lines}
   typedef struct packed {
      buf_word_t [1:0] mem;
      logic            wr_ptr;
      logic            rd_ptr;
      logic [1:0]      count;
   } buf_state_t;
   typedef struct packed {
      logic [2:0]  s1;        // first sync stage ch0, ch1, burst
      logic [2:0]  s2;
      logic        pending;
      logic        running;
      logic [19:0] phase;
      logic [3:0]  slot;
      logic        emitting;
      logic [19:0] emit_cnt;
      logic [5:0]  data;
      logic [15:0] strobe_n;
      logic        sync_n;
      logic [3:0]  word_len;
      logic        operate;
      logic [63:0] pmap;
      logic [19:0] period;
      logic [19:0] width;
      logic [31:0] rdata;
   } seq_state_t;
endpackage

/* File: verilog/readout_slot_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "readout_map.svh"
module readout_slot_buffer
(
   input  wire logic                   mclk_in,
   input  wire logic                   rst_in,
   input  wire logic                   ce_in,
   input  wire logic                   in_valid_in,
   output logic                        in_ready_out,
   input  wire readout_pkg::buf_word_t in_data_in,
   output logic                        out_valid_out,
   input  wire logic                   out_ready_in,
   output readout_pkg::buf_word_t      out_data_out
);
   import readout_pkg::*;
   buf_state_t st_q;
   buf_state_t st_d;
   logic       push;
   logic       pop;

   // handshakes straight from the fill level
   assign in_ready_out  = (st_q.count != 2'd2);
   assign out_valid_out = (st_q.count != 2'd0);
   assign out_data_out  = st_q.mem[st_q.rd_ptr];
   assign push = in_valid_in & in_ready_out;
   assign pop  = out_valid_out & out_ready_in;

   // two-entry ring addressed by pointer
   always_comb
   begin
      st_d = st_q;
      if (push)
      begin
         st_d.mem[st_q.wr_ptr] = in_data_in;
         st_d.wr_ptr = ~st_q.wr_ptr;
      end
      if (pop)
         st_d.rd_ptr = ~st_q.rd_ptr;
      st_d.count = st_q.count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         st_q <= '0;
      else if (ce_in)
         st_q <= st_d;
   end
endmodule
`default_nettype wire

/* File: test/printer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module printer_model
(
   input  wire logic        mclk_in,
   input  wire logic        hold_in,
   input  wire logic [5:0]  data_in,
   input  wire logic [15:0] strobe_n_in,
   input  wire logic        sync_n_in,
   output logic             ready_out
);
   logic [15:0] prev_q;
   logic [22:0] log_q [0:31];
   int          n_q = 0;
   // a held printer is busy and stalls the readout
   assign ready_out = !hold_in;
   // log each strobe start with sync and data lines, mark read as one
   always @(posedge mclk_in)
   begin
      prev_q <= strobe_n_in;
      if (prev_q == 16'hFFFF && strobe_n_in != 16'hFFFF)
      begin
         log_q[n_q[4:0]] <= {strobe_n_in, sync_n_in, data_in};
         n_q <= n_q + 1;
      end
   end
endmodule
`default_nettype wire

/* File: test/test_printer_digit_readout_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_printer_digit_readout_sequencer;
   logic        mclk_in = 1'b0;
   logic        rst_in  = 1'b1;
   logic [7:0]  addr    = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic        wr      = 1'b0;
   logic        rd      = 1'b0;
   logic        meas    = 1'b0;
   logic        ch1     = 1'b1;
   logic        ch0     = 1'b1;
   logic [31:0] dec     = 32'h8765_4321;
   logic        hold    = 1'b0;
   logic [3:0]  channel = 4'h0;
   logic [31:0] rdata;
   logic [5:0]  data;
   logic [15:0] strobe_n;
   logic        sync_n;
   logic        ready;
   logic [31:0] exp_q [0:7];
   logic [3:0]  chs [0:2] = '{4'h3, 4'h4, 4'h1};
   logic [3:0]  cmds [0:2] = '{4'h1, 4'h0, 4'h0};
   int          n_fail = 0;
   int          checks = 0;
   int          cyc = 0;
   int          i;

   printer_digit_readout_sequencer #(.PULSE_CYC(20'd10), .PERIOD_CYC(20'd40))
   u_printer_digit_readout_sequencer
   (
      .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .meas_done_in(meas), .ch0_active_in(ch0), .ch1_active_in(ch1),
      .burst_flag_in(1'b1), .channel_in(channel), .decades_in(dec),
      .printer_ready_in(ready), .data_out(data), .strobe_n_out(strobe_n),
      .sync_n_out(sync_n)
   );

   printer_model u_printer_model
   (
      .mclk_in(mclk_in), .hold_in(hold), .data_in(data),
      .strobe_n_in(strobe_n), .sync_n_in(sync_n), .ready_out(ready)
   );

   // clock and run limit
   initial
   begin
      forever #2.5 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (n_fail == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd_reg(a, v);
      chk("register", exp, v);
   endtask

   // expected log entry: one strobe low, sync level, marks on lines five and six
   function automatic logic [31:0] mk(input int p, input logic s, input logic [3:0] n);
      return {9'h000, ~(16'h0001 << p), s, 2'b11, n};
   endfunction

   // one readout: launch, early strobe count, wait for rest, compare log
   task automatic run_burst(input logic [3:0] ch, input int nexp, input logic stall,
                            input int early);
      logic [31:0] st;
      int          base;
      int          k;
      int          z;
      base = u_printer_model.n_q;
      @(posedge mclk_in);
      channel <= ch;
      hold <= stall;
      meas <= 1'b1;
      @(posedge mclk_in);
      meas <= 1'b0;
      repeat (300) @(posedge mclk_in);
      chk("early strobes", 32'(early), 32'(u_printer_model.n_q - base));
      if (early == 0)
      begin
         rd_reg(8'h14, st);
         chk("pending", 32'h2, st);
      end
      hold <= 1'b0;
      ch1 <= 1'b0;
      ch0 <= 1'b1;
      st = 32'h1;
      z = 0;
      // idle is seen twice in a row, since a buffered slot leaves a one-cycle gap
      for (k = 0; k < 20000 && z < 2; k++)
      begin
         rd_reg(8'h14, st);
         z = (st === 32'h0) ? z + 1 : 0;
      end
      chk("status", 32'h0, st);
      chk("slot count", 32'(nexp), 32'(u_printer_model.n_q - base));
      for (k = 0; k < nexp; k++)
         chk("slot", exp_q[k], 32'(u_printer_model.log_q[base + k]));
   endtask

   // main sequence
   initial
   begin
      repeat (3) @(posedge mclk_in);
      rst_in <= 1'b0;
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h0C, 32'h28);
      rd_chk(8'h10, 32'hA);
      rd_chk(8'h14, 32'h0);
      rd_chk(8'h20, 32'h0);
      chk("data idle", 32'h30, 32'(data));
      wr_reg(8'h0C, 32'h1004);
      rd_chk(8'h0C, 32'h1004);
      wr_reg(8'h04, 32'h0080_1230);
      wr_reg(8'h00, 32'h15);
      for (i = 0; i < 4; i++)
         exp_q[i] = mk(i + 1, 1'b0, 4'(4 - i));
      exp_q[4] = mk(5, 1'b0, 4'h2);
      run_burst(4'hF, 5, 1'b0, 0);
      wr_reg(8'h04, 32'h0000_0870);
      wr_reg(8'h00, 32'h12);
      dec <= 32'h9765_4321;
      for (i = 0; i < 3; i++)
      begin
         exp_q[0] = mk(1, 1'b0, 4'h9);
         exp_q[1] = mk(2, 1'b0, cmds[i]);
         run_burst(chs[i], 2, 1'b0, 1);
      end
      wr_reg(8'h0C, 32'h28);
      wr_reg(8'h04, 32'h0080_1230);
      wr_reg(8'h00, 32'h05);
      ch0 <= 1'b0;
      for (i = 0; i < 5; i++)
         exp_q[i] = mk(i + 1, 1'b1, (i < 4) ? 4'(4 - i) : 4'h0);
      run_burst(4'h4, 5, 1'b1, 0);
      print_verdict();
   end
endmodule
`default_nettype wire
